// *** hssp_consts.svh ***
/*
  Constants of the hub strap and status pin block: reset values of the
  latched strap levels and the width of the port power group.
  Assumes it is included by its bare name from each file that needs it.
*/
`ifndef HSSP_CONSTS_SVH
`define HSSP_CONSTS_SVH

// Number of downstream ports with a power control output.
`define HSSP_PORTS 4

// Strap levels assumed before sampling, matching each pin's pull.
`define HSSP_RST_SERIAL_STRAP  1'b1
`define HSSP_RST_PMDIS_STRAP   1'b0
`define HSSP_RST_POLARITY      1'b1
`define HSSP_RST_GANGED_STRAP  1'b0

// Idle level of the port 4 over-current pin, no event pending.
`define HSSP_RST_OC_LEVEL      1'b1

`endif

// *** hssp_far_model.sv ***
/*
  Far side of the serial pins: an SMBus host or an I2C EEPROM on an
  open-drain bus with board pull-ups.
  Assumes the bench hands it the mode that the board straps select.
*/
`timescale 1ns/1ps

module hssp_far_model (
  // Clock, board setting and far-side frame and data pull-down.
  input  wire logic ref_clk,
  input  wire logic smbus_mode,
  input  wire logic frame,
  input  wire logic far_sda_low,
  // Device pull-downs.
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // Resolved wires.
  output logic      scl_pin,
  output logic      sda_pin
);
  logic host_clk = 1'b1;

  // The host clock only toggles inside a frame, so it stands high between frames.
  always_ff @(posedge ref_clk)
  begin
    host_clk <= (smbus_mode && frame) ? ~host_clk : 1'b1;
  end

  // A released wire returns to the pull-up level; any party may pull it low.
  assign scl_pin = ~(scl_oe | ~host_clk);
  assign sda_pin = ~(sda_oe | far_sda_low);
endmodule

// *** hssp_pkg.sv ***
/*
  Types of the hub strap and status pin block: the sequencing states,
  the state records of both modules and the shared polarity function.
  Assumes hssp_consts.svh is reachable on the include path.
*/
`include "hssp_consts.svh"

package hssp_pkg;

  // Sequencing after reset, Gray coded along the only path.
  typedef enum logic [1:0]
  {
    HSSP_ST_RESET = 2'b00,
    HSSP_ST_LATCH = 2'b01,
    HSSP_ST_RUN   = 2'b11
  } hssp_state_t;

  // State of the strap latch.
  typedef struct packed
  {
    logic valid;
    logic serial_strap;
    logic pmdis_strap;
    logic polarity;
    logic ganged_strap;
  } hssp_strap_state_t;

  // State of the pin controller, every pin and status output registered.
  typedef struct packed
  {
    hssp_state_t               state;
    logic [`HSSP_PORTS-1:0]    pwr_out;
    logic [`HSSP_PORTS-1:0]    pwr_oe;
    logic                      ss_up_out;
    logic                      ss_up_oe;
    logic                      ss_susp_out;
    logic                      ss_susp_oe;
    logic                      scl_oe;
    logic                      sda_oe;
    logic                      scl_sense;
    logic                      sda_sense;
    logic                      i2c_en;
    logic                      smb_en;
    logic                      addr_bit1;
    logic                      addr_bit2;
    logic                      oc_prev;
    logic                      oc_level;
    logic                      oc_pulse;
  } hssp_main_t;

  // Maps a power request onto the pin level for the strapped polarity.
  function automatic logic hssp_apply_polarity(input logic on, input logic active_high);
    hssp_apply_polarity = active_high ? on : ~on;
  endfunction

endpackage

// *** hssp_strap_latch.sv ***
/*
  Strap latch: captures the four strap pin levels on one sample strobe
  and holds them until the next reset.
  Assumes the strobe comes once, at the first edge after reset release,
  and that the pins are not driven by the device at that moment.
*/
`timescale 1ns/1ps
`include "hssp_consts.svh"

module hssp_strap_latch (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset,
  // Sample strobe and raw pin levels.
  input  wire logic sample,
  input  wire logic serial_pin,
  input  wire logic pmdis_pin,
  input  wire logic polarity_pin,
  input  wire logic ganged_pin,
  // Latched levels.
  output logic      valid,
  output logic      serial_strap,
  output logic      pmdis_strap,
  output logic      polarity,
  output logic      ganged_strap
);
  import hssp_pkg::*;

  hssp_strap_state_t cur;
  hssp_strap_state_t next_cur;

  // Capture once; the levels then hold so a pin turned output cannot disturb them.
  always_comb
  begin
    next_cur = cur;
    if (sample && !cur.valid)
    begin
      next_cur.valid        = 1'b1;
      next_cur.serial_strap = serial_pin;
      next_cur.pmdis_strap  = pmdis_pin;
      next_cur.polarity     = polarity_pin;
      next_cur.ganged_strap = ganged_pin;
    end
  end

  // Reset restores the pull levels so decoding is defined before sampling.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cur.valid        <= 1'b0;
      cur.serial_strap <= `HSSP_RST_SERIAL_STRAP;
      cur.pmdis_strap  <= `HSSP_RST_PMDIS_STRAP;
      cur.polarity     <= `HSSP_RST_POLARITY;
      cur.ganged_strap <= `HSSP_RST_GANGED_STRAP;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign valid        = cur.valid;
  assign serial_strap = cur.serial_strap;
  assign pmdis_strap  = cur.pmdis_strap;
  assign polarity     = cur.polarity;
  assign ganged_strap = cur.ganged_strap;

endmodule

// *** hssp_top.sv ***
/*
  Hub strap and status pins: samples the strap pins at reset release,
  then turns shared pins into status outputs, steers the serial pins to
  the EEPROM master or the SMBus slave, drives the port power controls
  and watches the port 4 over-current input.
  Assumes all inputs are synchronous to ref_clk and the pad ring resolves
  each two-way pin from its output and output enable.
*/
// Overview of operation
// - Low on port 4 over-current pin is an event; high is none.
// - Serial mode pin sampled at reset release: high I2C, low SMBus.
// - In I2C mode the serial pins master an external EEPROM, clock driven.
// - In SMBus mode the host drives the clock; device answers as slave.
// - Power management strap low enables switching and over-current; high disables.
// - SMBus address bit 1 comes from the power management strap level.
// - When enabled, shared strap pin shows SuperSpeed connection status.
// - When enabled, serial mode pin shows SuperSpeed suspend status.
// - Polarity strap 0 makes power controls active low, 1 active high.
// - Full power management drives the four per-port power controls.
// - Ganged strap low gives per-port control, high gives ganged control.
// - SMBus address bit 2 comes from the ganged strap level.
`timescale 1ns/1ps
`include "hssp_consts.svh"

module hssp_top (
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // Serial mode strap and SuperSpeed suspend status pin.
  input  wire logic                   serial_mode_select_n_in,
  output logic                        serial_mode_select_n_out,
  output logic                        serial_mode_select_n_oe,
  // Power management strap, SMBus address bit 1 and SuperSpeed connection pin.
  input  wire logic                   power_management_disable_n_in,
  output logic                        power_management_disable_n_out,
  output logic                        power_management_disable_n_oe,
  // Polarity and ganged straps.
  input  wire logic                   power_control_polarity,
  input  wire logic                   ganged_select_in,
  // Port power control pins.
  output logic [`HSSP_PORTS-1:0]      port_power_control_out,
  output logic [`HSSP_PORTS-1:0]      port_power_control_oe,
  // Port 4 over-current pin.
  input  wire logic                   port4_overcurrent_n,
  // Serial clock and data pins, open drain.
  input  wire logic                   scl_in,
  output logic                        scl_out,
  output logic                        scl_oe,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  // Hub core requests and feature configuration.
  input  wire logic [`HSSP_PORTS-1:0] port_power_request,
  input  wire logic                   ss_connected,
  input  wire logic                   ss_suspended,
  input  wire logic                   ss_connect_status_enable,
  input  wire logic                   ss_suspend_status_enable,
  // Serial engines.
  input  wire logic                   i2c_scl_drive_low,
  input  wire logic                   i2c_sda_drive_low,
  input  wire logic                   smb_sda_drive_low,
  output logic                        i2c_master_enable,
  output logic                        smbus_slave_enable,
  output logic                        serial_scl_sense,
  output logic                        serial_sda_sense,
  // Decoded configuration and status.
  output logic                        strap_valid,
  output logic                        power_switching_enable,
  output logic                        ganged_power_mode,
  output logic                        smbus_addr_bit1_strap,
  output logic                        smbus_addr_bit2_strap,
  output logic                        port4_overcurrent_event,
  output logic                        port4_overcurrent_pulse
);
  import hssp_pkg::*;

  hssp_main_t cur;
  hssp_main_t next_cur;
  logic       serial_strap;
  logic       pmdis_strap;
  logic       polarity_strap;
  logic       ganged_strap;
  logic       strap_sample;

  // Straps are caught on the first edge after reset release, pins still inputs.
  assign strap_sample = (cur.state == HSSP_ST_RESET);

  hssp_strap_latch u_strap (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .sample       (strap_sample),
    .serial_pin   (serial_mode_select_n_in),
    .pmdis_pin    (power_management_disable_n_in),
    .polarity_pin (power_control_polarity),
    .ganged_pin   (ganged_select_in),
    .valid        (strap_valid),
    .serial_strap (serial_strap),
    .pmdis_strap  (pmdis_strap),
    .polarity     (polarity_strap),
    .ganged_strap (ganged_strap)
  );

  // Next state of every pin and status flop.
  always_comb
  begin
    logic run;
    logic i2c_mode;
    logic pm_en;
    logic any_req;
    logic on;
    run      = 1'b0;
    i2c_mode = 1'b0;
    pm_en    = 1'b0;
    any_req  = 1'b0;
    on       = 1'b0;
    next_cur = cur;
    case (cur.state)
      HSSP_ST_RESET: next_cur.state = HSSP_ST_LATCH;
      HSSP_ST_LATCH: next_cur.state = HSSP_ST_RUN;
      default:       next_cur.state = HSSP_ST_RUN;
    endcase
    // Nothing drives until the straps are held, so sampling sees only the board.
    run      = strap_valid;
    i2c_mode = serial_strap;
    pm_en    = ~pmdis_strap;
    any_req  = |port_power_request;
    for (int i = 0; i < `HSSP_PORTS; i++)
    begin
      on                  = ganged_strap ? any_req : port_power_request[i];
      next_cur.pwr_out[i] = hssp_apply_polarity(on, polarity_strap);
      next_cur.pwr_oe[i]  = run & pm_en;
    end
    // Status pins drive the level the core reports once the feature is enabled.
    next_cur.ss_up_oe    = run & ss_connect_status_enable;
    next_cur.ss_up_out   = run & ss_connect_status_enable & ss_connected;
    next_cur.ss_susp_oe  = run & ss_suspend_status_enable;
    next_cur.ss_susp_out = run & ss_suspend_status_enable & ss_suspended;
    // The clock is only pulled low by the EEPROM master; the SMBus host owns it.
    next_cur.scl_oe    = run & i2c_mode & i2c_scl_drive_low;
    next_cur.sda_oe    = run & (i2c_mode ? i2c_sda_drive_low : smb_sda_drive_low);
    next_cur.scl_sense = scl_in;
    next_cur.sda_sense = sda_in;
    next_cur.i2c_en    = run & i2c_mode;
    next_cur.smb_en    = run & ~i2c_mode;
    next_cur.addr_bit1 = run & ~i2c_mode & pmdis_strap;
    next_cur.addr_bit2 = run & ~i2c_mode & ganged_strap;
    // Only a falling pin counts as a new event; a held low stays one event.
    next_cur.oc_prev  = port4_overcurrent_n;
    next_cur.oc_level = run & pm_en & ~port4_overcurrent_n;
    next_cur.oc_pulse = run & pm_en & cur.oc_prev & ~port4_overcurrent_n;
  end

  // Single state register; reset releases every pin.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cur          <= '0;
      cur.state    <= HSSP_ST_RESET;
      cur.oc_prev  <= `HSSP_RST_OC_LEVEL;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Open-drain serial pins only ever pull low.
  assign scl_out                        = 1'b0;
  assign sda_out                        = 1'b0;
  assign scl_oe                         = cur.scl_oe;
  assign sda_oe                         = cur.sda_oe;
  assign serial_mode_select_n_out       = cur.ss_susp_out;
  assign serial_mode_select_n_oe        = cur.ss_susp_oe;
  assign power_management_disable_n_out = cur.ss_up_out;
  assign power_management_disable_n_oe  = cur.ss_up_oe;
  assign port_power_control_out         = cur.pwr_out;
  assign port_power_control_oe          = cur.pwr_oe;
  assign i2c_master_enable              = cur.i2c_en;
  assign smbus_slave_enable             = cur.smb_en;
  assign serial_scl_sense               = cur.scl_sense;
  assign serial_sda_sense               = cur.sda_sense;
  assign power_switching_enable         = ~pmdis_strap;
  assign ganged_power_mode              = ganged_strap;
  assign smbus_addr_bit1_strap          = cur.addr_bit1;
  assign smbus_addr_bit2_strap          = cur.addr_bit2;
  assign port4_overcurrent_event        = cur.oc_level;
  assign port4_overcurrent_pulse        = cur.oc_pulse;

  // Checks of pin behaviour against the latched straps.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  oc_event_a: assert property ((strap_valid && !pmdis_strap && !port4_overcurrent_n)
    |=> port4_overcurrent_event)
    else $error("Over-current low level not reported");
  oc_idle_a: assert property (port4_overcurrent_n |=> !port4_overcurrent_event)
    else $error("Over-current reported while pin high");
  serial_sample_a: assert property (strap_sample
    |=> (serial_strap == $past(serial_mode_select_n_in)))
    else $error("Serial mode strap not taken at reset release");
  serial_hold_a: assert property ((strap_valid && $past(strap_valid)) |-> $stable(serial_strap))
    else $error("Serial mode changed after sampling");
  i2c_clock_a: assert property ((strap_valid && serial_strap && i2c_scl_drive_low)
    |=> scl_oe && i2c_master_enable)
    else $error("I2C master clock not driven");
  smbus_clock_a: assert property ((strap_valid && !serial_strap)
    |=> !scl_oe && smbus_slave_enable)
    else $error("Clock driven in SMBus mode");
  pm_disable_a: assert property ((strap_valid && pmdis_strap)
    |=> (port_power_control_oe == 4'h0) && !port4_overcurrent_event)
    else $error("Power pins active while power management disabled");
  addr_bit1_a: assert property ((strap_valid && !serial_strap)
    |=> (smbus_addr_bit1_strap == pmdis_strap))
    else $error("SMBus address bit 1 differs from strap");
  ss_connect_a: assert property ((strap_valid && ss_connect_status_enable)
    |=> power_management_disable_n_oe
        && (power_management_disable_n_out == $past(ss_connected)))
    else $error("Connection status pin wrong");
  ss_suspend_a: assert property ((strap_valid && ss_suspend_status_enable)
    |=> serial_mode_select_n_oe
        && (serial_mode_select_n_out == $past(ss_suspended)))
    else $error("Suspend status pin wrong");
  port_polarity_a: assert property ((strap_valid && !pmdis_strap && !ganged_strap)
    |=> (port_power_control_out == (polarity_strap ? $past(port_power_request) : ~$past(port_power_request)))
        && (port_power_control_oe == 4'hF))
    else $error("Per-port power control level wrong");
  ganged_power_a: assert property ((strap_valid && !pmdis_strap && ganged_strap && |port_power_request)
    |=> (port_power_control_out == (polarity_strap ? 4'hF : 4'h0)))
    else $error("Ganged ports not switched together");
  addr_bit2_a: assert property ((strap_valid && !serial_strap)
    |=> (smbus_addr_bit2_strap == ganged_strap))
    else $error("SMBus address bit 2 differs from strap");
  strap_hold_a: assert property (!strap_valid
    |-> !serial_mode_select_n_oe && !power_management_disable_n_oe && (port_power_control_oe == 4'h0))
    else $error("Shared pin driven before straps latched");

  oc_pulse_c: cover property (port4_overcurrent_pulse);
  i2c_drive_c: cover property (scl_oe && i2c_master_enable);
  smbus_mode_c: cover property (smbus_slave_enable && sda_oe);
  ganged_on_c: cover property (ganged_power_mode && (port_power_control_oe == 4'hF));

endmodule

// *** testbench.sv ***
/*
  Bench of the strap and status pin block: runs every strap setting through
  a reset and compares each output with a cycle model of the pins.
  Assumes the design answers one cycle after each sampling edge.
*/
`timescale 1ns/1ps

module testbench;
  logic ref_clk = 1'b0, reset = 1'b1, frame = 1'b0, far_sda = 1'b0;
  logic ser_pull = 1'b1, pmd_pull = 1'b0, pol_pin = 1'b1, gang_pin = 1'b0, oc_n = 1'b1;
  logic [3:0] req = 4'h0, combo = 4'h8;
  logic ss_c = 1'b0, ss_s = 1'b0, ss_ce = 1'b0, ss_se = 1'b0, i_scl = 1'b0, i_sda = 1'b0, s_sda = 1'b0;
  logic ser_out, ser_oe, pmd_out, pmd_oe, scl_o, scl_oe, sda_o, sda_oe, i2c_en, smb_en;
  logic scl_s, sda_s, sv, pse, gpm, a1, a2, oce, ocp;
  logic [3:0] ppc_out, ppc_oe, p_req;
  logic l_ser, l_pmd, l_pol, l_gang, p_c, p_s, p_ce, p_se, p_isc, p_isd, p_smb, p_scl, p_sda, p_oc, pp_oc;
  logic [16:0] seed = 17'h159BE;
  logic [3:0] req_q[$];
  wire scl_pin, sda_pin;
  wire ser_pin = ser_oe ? ser_out : ser_pull;
  wire pmd_pin = pmd_oe ? pmd_out : pmd_pull;
  int n_fail = 0, num_checks = 0, cnt = 0;

  hssp_top dut_u (.ref_clk(ref_clk), .reset(reset),
    .serial_mode_select_n_in(ser_pin), .serial_mode_select_n_out(ser_out), .serial_mode_select_n_oe(ser_oe),
    .power_management_disable_n_in(pmd_pin), .power_management_disable_n_out(pmd_out),
    .power_management_disable_n_oe(pmd_oe), .power_control_polarity(pol_pin), .ganged_select_in(gang_pin),
    .port_power_control_out(ppc_out), .port_power_control_oe(ppc_oe), .port4_overcurrent_n(oc_n),
    .scl_in(scl_pin), .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda_pin), .sda_out(sda_o), .sda_oe(sda_oe),
    .port_power_request(req), .ss_connected(ss_c), .ss_suspended(ss_s),
    .ss_connect_status_enable(ss_ce), .ss_suspend_status_enable(ss_se),
    .i2c_scl_drive_low(i_scl), .i2c_sda_drive_low(i_sda), .smb_sda_drive_low(s_sda),
    .i2c_master_enable(i2c_en), .smbus_slave_enable(smb_en), .serial_scl_sense(scl_s),
    .serial_sda_sense(sda_s), .strap_valid(sv), .power_switching_enable(pse), .ganged_power_mode(gpm),
    .smbus_addr_bit1_strap(a1), .smbus_addr_bit2_strap(a2),
    .port4_overcurrent_event(oce), .port4_overcurrent_pulse(ocp));

  hssp_far_model far_u (.ref_clk(ref_clk), .smbus_mode(~combo[3]), .frame(frame), .far_sda_low(far_sda),
    .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_pin(scl_pin), .sda_pin(sda_pin));

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction

  // Expected switch levels: ganged ports follow the OR of all requests.
  function automatic logic [3:0] exp_pwr(input logic [3:0] r, input logic pol, input logic gang);
    logic [3:0] v;
    v = gang ? {4{|r}} : r;
    exp_pwr = pol ? v : ~v;
  endfunction

  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_vec(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  // Straps stay put through reset and the sampling edge, then wander to prove they are ignored.
  always @(posedge ref_clk)
  begin
    seed = lfsr(seed);
    {req, ss_c, ss_s, ss_ce, ss_se} <= seed[7:0];
    {i_scl, i_sda, s_sda, frame, far_sda} <= seed[12:8];
    oc_n <= (cnt < 4) | seed[13] | seed[14];
    if (reset || cnt == 0)
      {ser_pull, pmd_pull, pol_pin, gang_pin} <= combo;
    else
      {ser_pull, pmd_pull, pol_pin, gang_pin} <= seed[16:13];
  end

  // Reference model: latch at the first edge out of reset, capture every input edge.
  always @(posedge ref_clk)
  begin
    cnt <= reset ? 0 : cnt + 1;
    if (!reset && cnt == 0)
      {l_ser, l_pmd, l_pol, l_gang} <= {ser_pin, pmd_pin, pol_pin, gang_pin};
    req_q.push_back(req);
    {p_c, p_s, p_ce, p_se} <= {ss_c, ss_s, ss_ce, ss_se};
    {p_isc, p_isd, p_smb, p_scl, p_sda} <= {i_scl, i_sda, s_sda, scl_pin, sda_pin};
    {pp_oc, p_oc} <= {p_oc, oc_n};
  end

  // Outputs are settled by the falling edge.
  always @(negedge ref_clk)
  begin
    if (req_q.size() != 0)
      p_req = req_q.pop_front();
    if (cnt == 1)
    begin
      chk_bit("strap_valid", 1'b1, sv);
      chk_vec("pwr_oe_early", 4'h0, ppc_oe);
      chk_bit("susp_oe_early", 1'b0, ser_oe);
      chk_bit("conn_oe_early", 1'b0, pmd_oe);
    end
    if (cnt >= 2)
    begin
      chk_bit("i2c_en", l_ser, i2c_en);
      chk_bit("smb_en", ~l_ser, smb_en);
      chk_bit("pwr_sw_en", ~l_pmd, pse);
      chk_bit("ganged", l_gang, gpm);
      chk_bit("addr_bit1", ~l_ser & l_pmd, a1);
      chk_bit("addr_bit2", ~l_ser & l_gang, a2);
      chk_vec("pwr_oe", l_pmd ? 4'h0 : 4'hF, ppc_oe);
      if (!l_pmd)
        chk_vec("pwr_out", exp_pwr(p_req, l_pol, l_gang), ppc_out);
      chk_bit("conn_oe", p_ce, pmd_oe);
      if (p_ce)
        chk_bit("conn_out", p_c, pmd_out);
      chk_bit("susp_oe", p_se, ser_oe);
      if (p_se)
        chk_bit("susp_out", p_s, ser_out);
      chk_bit("scl_oe", l_ser & p_isc, scl_oe);
      chk_bit("sda_oe", l_ser ? p_isd : p_smb, sda_oe);
      chk_bit("scl_out", 1'b0, scl_o);
      chk_bit("sda_out", 1'b0, sda_o);
      chk_bit("scl_sense", p_scl, scl_s);
      chk_bit("sda_sense", p_sda, sda_s);
      chk_bit("oc_event", ~l_pmd & ~p_oc, oce);
      chk_bit("oc_pulse", ~l_pmd & ~p_oc & pp_oc, ocp);
    end
  end

  // Every strap setting gets its own reset, each one in the middle of running traffic.
  initial
  begin
    for (int k = 0; k < 16; k++)
    begin
      combo <= k[3:0];
      reset <= 1'b1;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (40) @(posedge ref_clk);
    end
    end_sim();
  end

  // The run needs about 720 cycles; far beyond that it is hung.
  initial
  begin
    #20000;
    n_fail++;
    end_sim();
  end
endmodule
